// file: hw_window_consts.svh
`ifndef HW_WINDOW_CONSTS_SVH
`define HW_WINDOW_CONSTS_SVH

// Display memory address width per axis (4096 pixels).
`define ADDR_BITS 12
// Bits per display memory word.
`define WORD_BITS 16
// Low X address bits that select a bit inside a word.
`define BIT_SEL_BITS 4
// Number of bit planes served by one device.
`define PLANE_COUNT 4
// Bit count signalled for a complete byte.
`define FULL_BYTE_COUNT 4'h8
// Bits per byte.
`define BYTE_BITS 8
// Reset value of the position counters.
`define POS_RESET 12'h000
// Assembly FIFO depth in bytes, the look-ahead margin of the fetch.
`define ASM_DEPTH 64
// Fetch refills once the FIFO level drops below this many bytes.
`define LOW_WATER 16

`endif

// file: hw_window_pkg.sv
package hw_window_pkg;

  // Fetch sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_XFER = 3'b001,
    ST_MOVE = 3'b010,
    ST_WAIT = 3'b011,
    ST_DONE = 3'b100
  } fetch_state_e;

  // Kind of segment being fetched on a scan line.
  typedef enum logic [1:0] {
    SEG_LEFT = 2'b00,
    SEG_WIN = 2'b01,
    SEG_RIGHT = 2'b10
  } seg_kind_e;

endpackage

// file: vid_fetch_if.sv
`timescale 1ns/1ps
// Link between the fetch sequencer and the video assembly FIFO.
interface vid_fetch_if;
  // High in the cycle of a transfer cycle; bit_count_pins carries first bit index.
  logic xfer;
  // High while one unit moves from VRAM into the assembly FIFO.
  logic unit_valid;
  // First bit index during xfer, else used bit count of the unit (1..16).
  logic [4:0] bit_count_pins;
  // Serial data word, 16 bits per plane, four planes.
  logic [63:0] unit_data;
  // Memory address driven during the transfer cycle, X without low four bits.
  logic [19:0] mem_addr;
  // Assembly FIFO fill level in bytes.
  logic [7:0] fifo_level;

  modport fetch(output xfer, output unit_valid, output bit_count_pins, output unit_data,
    output mem_addr, input fifo_level);
  modport asm_fifo(input xfer, input unit_valid, input bit_count_pins, input unit_data,
    input mem_addr, output fifo_level);
endinterface

// file: hw_window_fetch.sv
`timescale 1ns/1ps
// Overview of operation
// - Window image shown without modifying memory.
// - Rectangular window at any bit position.
// - Word access; one transfer per plain line.
// - Transfers at window start and window end.
// - First valid bit index during transfers.
// - Per-unit valid bit count, short first and last.
// - After window transfer, index then counts.
// - Assembly FIFO packs valid bits into bytes.
// - Fetch runs ahead using FIFO buffering.
// - All four planes substituted together.
// - Equal real and apparent origin: no effect.
// - All devices share apparent window geometry.
// - Window registers changed only at frame start.
// - Four registers set apparent window position.
// - Off-screen apparent window shows nothing.
// - Real pointers scroll window contents.
// - Twelve address bits per axis.
// - Low four X bits never driven.
// - Sixteen data bits per plane per bank.
`include "hw_window_consts.svh"
module hw_window_fetch
  import hw_window_pkg::*;
#(
  parameter int AW = `ADDR_BITS
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Line control: pulse starts a line fetch for line y.
  input wire logic i_line_start,
  input wire logic [AW-1:0] i_line_y,
  // Screen origin in memory and visible width.
  input wire logic [AW-1:0] i_screen_x,
  input wire logic [AW-1:0] i_screen_y,
  input wire logic [AW-1:0] i_screen_w,
  // Apparent window: four position/size registers.
  input wire logic [AW-1:0] i_app_x0,
  input wire logic [AW-1:0] i_app_y0,
  input wire logic [AW-1:0] i_app_x1,
  input wire logic [AW-1:0] i_app_y1,
  // Real window origin in memory.
  input wire logic [AW-1:0] i_real_x,
  input wire logic [AW-1:0] i_real_y,
  // Window enable and frame start event.
  input wire logic i_win_en,
  input wire logic i_frame_start_event,
  // VRAM serial word, 16 bits per plane.
  input wire logic [`WORD_BITS*`PLANE_COUNT-1:0] i_vram_data,
  // Line fetch finished.
  output logic o_line_done,
  // Link to the assembly FIFO.
  vid_fetch_if.fetch lnk
);

  // Whole state of the sequencer in one record.
  typedef struct packed {
    fetch_state_e st;
    seg_kind_e seg;
    logic [AW-1:0] ax0, ay0, ax1, ay1, rx, ry;
    logic win_en;
    logic [AW:0] pos;
    logic [AW:0] seg_end;
    logic [AW-1:0] src_x;
    logic [AW-1:0] src_y;
    logic xfer;
    logic unit_valid;
    logic [4:0] bcp;
    logic [63:0] data;
    logic [19:0] addr;
    logic done;
  } fetch_s;

  fetch_s cur;
  fetch_s nxt;
  logic [AW:0] scr_end;
  logic on_line;
  logic [4:0] left_in_word;
  logic [AW:0] remain;
  logic [4:0] take;

  // Line geometry, computed combinationally from the latched window.
  always_comb begin
    scr_end = {1'b0, i_screen_x} + {1'b0, i_screen_w};
    // off-screen window never matches a visible line or column.
    on_line = cur.win_en && (i_line_y >= cur.ay0) && (i_line_y <= cur.ay1)
      && ({1'b0, cur.ax0} < scr_end) && (cur.ax1 >= i_screen_x);
    // any bit position may end a segment.
    left_in_word = 5'h10 - {1'b0, cur.src_x[`BIT_SEL_BITS-1:0]};
    remain = cur.seg_end - cur.pos;
    take = (remain < {1'b0, 7'h0, left_in_word}) ? remain[4:0] : left_in_word;
  end

  // Next-state logic of the fetch sequencer.
  always_comb begin
    nxt = cur;
    nxt.xfer = 1'b0;
    nxt.unit_valid = 1'b0;
    nxt.done = 1'b0;
    // window registers sampled only at frame start.
    if (i_frame_start_event) begin
      // four apparent registers, two per axis.
      nxt.ax0 = i_app_x0;
      nxt.ax1 = i_app_x1;
      nxt.ay0 = i_app_y0;
      nxt.ay1 = i_app_y1;
      nxt.rx = i_real_x;
      nxt.ry = i_real_y;
      nxt.win_en = i_win_en;
    end
    case (cur.st)
      ST_IDLE: begin
        if (i_line_start) begin
          nxt.pos = {1'b0, i_screen_x};
          nxt.seg = SEG_LEFT;
          nxt.src_x = i_screen_x;
          nxt.src_y = i_line_y;
          // no window, one transfer covers the whole line.
          nxt.seg_end = (on_line && cur.ax0 > i_screen_x) ? {1'b0, cur.ax0} : scr_end;
          // window starting at screen origin jumps straight in.
          if (on_line && cur.ax0 <= i_screen_x) begin
            nxt.seg = SEG_WIN;
            // real pointers choose the window source.
            nxt.src_x = cur.rx + (i_screen_x - cur.ax0);
            nxt.src_y = cur.ry + (i_line_y - cur.ay0);
            nxt.seg_end = ({1'b0, cur.ax1} + 13'h1 < scr_end) ? {1'b0, cur.ax1} + 13'h1
              : scr_end;
          end
          nxt.st = ST_XFER;
        end
      end
      ST_XFER: begin
        // transfer cycle carries the first valid bit index.
        nxt.xfer = 1'b1;
        nxt.bcp = {1'b0, cur.src_x[`BIT_SEL_BITS-1:0]};
        // only X[11:4] and Y reach the address bus.
        nxt.addr = {cur.src_y, cur.src_x[AW-1:`BIT_SEL_BITS]};
        nxt.st = ST_MOVE;
      end
      ST_MOVE: begin
        // stall only when the FIFO holds plenty of look-ahead.
        if (lnk.fifo_level >= 8'(`ASM_DEPTH - `WORD_BITS)) begin
          nxt.st = ST_WAIT;
        end else begin
          // unit count is full width except a short first and last one.
          nxt.unit_valid = 1'b1;
          nxt.bcp = take;
          // all four planes move together; 16 bits each.
          nxt.data = i_vram_data;
          nxt.pos = cur.pos + {8'h0, take};
          nxt.src_x = cur.src_x + {7'h0, take};
          if (cur.pos + {8'h0, take} >= cur.seg_end) begin
            nxt.st = ST_XFER;
            if (cur.seg == SEG_LEFT && cur.seg_end < scr_end) begin
              // window-start transfer; index then counts follow.
              nxt.seg = SEG_WIN;
              // The segment opens at the window's own left edge, so no offset is added.
              nxt.src_x = cur.rx;
              nxt.src_y = cur.ry + (i_line_y - cur.ay0);
              nxt.seg_end = ({1'b0, cur.ax1} + 13'h1 < scr_end) ? {1'b0, cur.ax1} + 13'h1
                : scr_end;
            end else if (cur.seg == SEG_WIN && cur.seg_end < scr_end) begin
              // window-end transfer fetches the right background.
              nxt.seg = SEG_RIGHT;
              nxt.src_x = cur.seg_end[AW-1:0];
              nxt.src_y = i_line_y;
              nxt.seg_end = scr_end;
            end else begin
              nxt.st = ST_DONE;
            end
          end
        end
      end
      ST_WAIT: begin
        // resume well before the FIFO can drain.
        if (lnk.fifo_level < 8'(`LOW_WATER)) begin
          nxt.st = ST_MOVE;
        end
      end
      ST_DONE: begin
        nxt.done = 1'b1;
        nxt.st = ST_IDLE;
      end
      default: begin
        nxt.st = ST_IDLE;
      end
    endcase
  end

  // State register, synchronous reset.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  // outputs only read memory; no write path exists.
  assign lnk.xfer = cur.xfer;
  assign lnk.unit_valid = cur.unit_valid;
  assign lnk.bit_count_pins = cur.bcp;
  assign lnk.unit_data = cur.data;
  assign lnk.mem_addr = cur.addr;
  assign o_line_done = cur.done;

endmodule // hw_window_fetch

// file: video_assembly_fifo.sv
`timescale 1ns/1ps
`include "hw_window_consts.svh"
module video_assembly_fifo
  import hw_window_pkg::*;
#(
  parameter int DEPTH = `ASM_DEPTH
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Link from the fetch sequencer.
  vid_fetch_if.asm_fifo lnk,
  // Pixel side byte output, one plane byte lane per plane.
  input wire logic i_pix_ready,
  output logic o_pix_valid,
  output logic [`BYTE_BITS*`PLANE_COUNT-1:0] o_pix_byte
);

  // Whole state of the assembler except the byte storage.
  typedef struct packed {
    logic [3:0] first;
    logic [4:0] fill;
    logic [4*24-1:0] acc;
    logic [7:0] level;
    logic [5:0] wr;
    logic [5:0] rd;
    logic pv;
    logic [31:0] pb;
  } asm_s;

  asm_s cur;
  asm_s nxt;
  logic [31:0] mem [0:DEPTH-1];
  // Bytes completed by this unit: none, one or two.
  logic [1:0] n_push;
  // Output register takes a byte from storage this cycle.
  logic load;
  logic pop;
  // Older and younger completed byte, one lane per plane.
  logic [31:0] byte_a;
  logic [31:0] byte_b;
  logic [4:0] cnt;
  // Valid bits held once this unit is appended, at most 23.
  logic [4:0] tot;
  // Selected bits of one plane, right aligned.
  logic [15:0] sel;

  // Byte packing: valid bits are appended MSB first per plane.
  always_comb begin
    nxt = cur;
    n_push = 2'h0;
    load = 1'b0;
    byte_a = '0;
    byte_b = '0;
    sel = 16'h0;
    cnt = lnk.bit_count_pins;
    tot = cur.fill + cnt;
    pop = cur.pv && i_pix_ready;
    if (pop) begin
      nxt.pv = 1'b0;
    end
    if (lnk.xfer) begin
      nxt.first = lnk.bit_count_pins[3:0];
    end
    if (lnk.unit_valid) begin
      // select the indicated bits and pack them into bytes.
      for (int p = 0; p < 4; p++) begin
        // Kept at word width so the bits ahead of the first valid one fall off the top.
        sel = (lnk.unit_data[p*16 +: 16] << cur.first) >> (5'd16 - cnt);
        nxt.acc[p*24 +: 24] = (cur.acc[p*24 +: 24] << cnt) | {8'h00, sel};
      end
      nxt.first = 4'(cur.first + cnt[3:0]);
      // A whole word can finish two bytes, so up to two leave per unit; else bits pile up.
      if (tot >= 5'd16) begin
        n_push = 2'h2;
        nxt.fill = tot - 5'd16;
      end else if (tot >= 5'd8) begin
        n_push = 2'h1;
        nxt.fill = tot - 5'd8;
      end else begin
        nxt.fill = tot;
      end
      // The older byte sits above the younger one in the accumulator.
      for (int p = 0; p < 4; p++) begin
        byte_a[p*8 +: 8] = 8'(nxt.acc[p*24 +: 24] >> (tot - 5'd8));
        byte_b[p*8 +: 8] = 8'(nxt.acc[p*24 +: 24] >> (tot - 5'd16));
      end
    end
    nxt.wr = cur.wr + {4'h0, n_push};
    // Refill the output register whenever it is free and storage holds a byte.
    load = !nxt.pv && cur.level != 8'h0;
    if (load) begin
      nxt.pv = 1'b1;
      nxt.pb = mem[cur.rd];
      nxt.rd = cur.rd + 6'h1;
    end
    // The level counts stored bytes only, not the one in the output register.
    nxt.level = cur.level + {6'h0, n_push} - {7'h0, load};
  end

  // Storage write port, two bytes per cycle at most.
  always_ff @(posedge i_ref_clk) begin
    if (n_push != 2'h0) begin
      mem[cur.wr] <= byte_a;
    end
    if (n_push == 2'h2) begin
      mem[cur.wr + 6'h1] <= byte_b;
    end
  end

  // State register.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign lnk.fifo_level = cur.level;
  assign o_pix_valid = cur.pv;
  assign o_pix_byte = cur.pb;

endmodule // video_assembly_fifo

// file: hw_window_fetch_sva.sv
`timescale 1ns/1ps
// Watches the link between the two ends; every check shares one clock domain.
module hw_window_fetch_sva #(
  parameter int DEPTH = 64
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Link signals.
  input wire logic xfer,
  input wire logic unit_valid,
  input wire logic [4:0] bit_count_pins,
  input wire logic [7:0] fifo_level
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  // The link must be quiet at the first edge after reset is released.
  rst_quiet_a: assert property (disable iff (1'b0) $fell(i_sys_rst) |-> !xfer && !unit_valid)
    else $error("Link active right after reset.");
  xfer_pulse_a: assert property (xfer |=> !xfer)
    else $error("Transfer cycle longer than one clock.");
  first_bit_a: assert property (xfer |-> bit_count_pins < 5'h10)
    else $error("First bit index outside a word.");
  unit_count_a: assert property (unit_valid |-> bit_count_pins inside {[1:16]})
    else $error("Unit bit count out of range.");
  no_overlap_a: assert property (!(xfer && unit_valid))
    else $error("Unit moved during a transfer cycle.");
  level_bound_a: assert property (fifo_level <= DEPTH)
    else $error("Assembly level above its depth.");
  // Pipeline lag of the registered link is allowed three cycles before the stall shows.
  stall_a: assert property ((fifo_level >= 8'h30) [*3] |=> !unit_valid)
    else $error("Units moved into a nearly full assembly FIFO.");
  unit_follow_a: assert property (xfer && fifo_level < 8'h10 |-> ##[1:8] unit_valid)
    else $error("No unit after a transfer cycle.");
endmodule // hw_window_fetch_sva

// file: tb.sv
`timescale 1ns/1ps
// Both ends joined by one link; a word model of VRAM feeds address-coded data.
module tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic line_start = 1'b0;
  logic [11:0] line_y = 12'h000;
  logic [11:0] screen_x = 12'h013;
  logic [11:0] screen_y = 12'h000;
  logic [11:0] screen_w = 12'h0a0;
  logic [11:0] app_x0 = 12'h000;
  logic [11:0] app_y0 = 12'h003;
  logic [11:0] app_x1 = 12'h000;
  logic [11:0] app_y1 = 12'h009;
  logic [11:0] real_x = 12'h000;
  logic [11:0] real_y = 12'h000;
  logic win_en = 1'b0;
  logic frame_ev = 1'b0;
  logic [63:0] vram;
  logic line_done;
  logic pix_ready = 1'b1;
  logic pix_valid;
  logic [31:0] pix_byte;
  // Observed per line: transfer cycles, their index and address, bits and a pixel signature.
  int xfers = 0;
  int bits = 0;
  int cycles = 0;
  int miscompares = 0;
  int n_checks = 0;
  logic [4:0] xbit [0:7];
  logic [19:0] xaddr [0:7];
  logic [31:0] ck = 32'h0;
  logic [31:0] ck_ref = 32'h0;
  logic [19:0] ptr = 20'h0;
  bit done_seen = 1'b0;

  vid_fetch_if lnk();
  hw_window_fetch #(.AW(12)) i_hw_window_fetch(.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .i_line_start(line_start), .i_line_y(line_y), .i_screen_x(screen_x),
    .i_screen_y(screen_y), .i_screen_w(screen_w), .i_app_x0(app_x0), .i_app_y0(app_y0),
    .i_app_x1(app_x1), .i_app_y1(app_y1), .i_real_x(real_x), .i_real_y(real_y),
    .i_win_en(win_en), .i_frame_start_event(frame_ev), .i_vram_data(vram),
    .o_line_done(line_done), .lnk(lnk));
  video_assembly_fifo #(.DEPTH(64)) i_video_assembly_fifo(.i_ref_clk(ref_clk),
    .i_sys_rst(sys_rst), .lnk(lnk), .i_pix_ready(pix_ready), .o_pix_valid(pix_valid),
    .o_pix_byte(pix_byte));
  hw_window_fetch_sva #(.DEPTH(64)) i_hw_window_fetch_sva(.i_ref_clk(ref_clk),
    .i_sys_rst(sys_rst), .xfer(lnk.xfer), .unit_valid(lnk.unit_valid),
    .bit_count_pins(lnk.bit_count_pins), .fifo_level(lnk.fifo_level));

  // Clock of 5 ns period.
  always #2.5 ref_clk = ~ref_clk;

  // Each word holds a pattern of its own address, different in every plane.
  function automatic logic [63:0] word_of(input logic [19:0] a);
    return {a[15:0], ~a[15:0], a[15:0] ^ 16'h5a5a, a[19:4]};
  endfunction

  // The fetch samples the word in the transfer cycle itself and in each later cycle that issues a unit,
  // so the serial word is the transfer address plus the units already issued.
  always_comb begin
    vram = word_of(lnk.xfer === 1'b1 ? lnk.mem_addr : ptr + {19'h0, lnk.unit_valid});
  end

  // Word pointer and per-line observations.
  always @(posedge ref_clk) begin
    if (lnk.xfer === 1'b1) begin
      xbit[xfers] = lnk.bit_count_pins;
      xaddr[xfers] = lnk.mem_addr;
      xfers++;
      ptr <= lnk.mem_addr;
    end else if (lnk.unit_valid === 1'b1) begin
      bits += lnk.bit_count_pins;
      ptr <= ptr + 20'h1;
    end
    if (line_done === 1'b1) done_seen = 1'b1;
    if (pix_valid === 1'b1 && pix_ready) ck = {ck[30:0], ck[31]} ^ pix_byte;
  end

  task automatic err(input string m);
    miscompares++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  function automatic bit ne(input logic [31:0] a, input logic [31:0] b);
    n_checks++;
    return a !== b;
  endfunction

  // Reference pixel signature of a plain line, built bit by bit from the word model.
  function automatic logic [31:0] plain_ck(input logic [11:0] y);
    logic [31:0] c;
    logic [31:0] b;
    logic [63:0] w;
    logic [11:0] x;
    c = 32'h0;
    b = 32'h0;
    for (int i = 0; i < 160; i++) begin
      x = 12'h013 + 12'(i);
      w = word_of({y, x[11:4]});
      // Pixel zero of a word is its most significant bit, in every plane.
      for (int p = 0; p < 4; p++) begin
        b[p*8 +: 8] = {b[p*8 +: 7], w[p*16 + 15 - int'(x[3:0])]};
      end
      if (i % 8 == 7) begin
        c = {c[30:0], c[31]} ^ b;
      end
    end
    return c;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Window registers only take effect at the frame start event.
  task automatic set_win(input logic en, input logic [11:0] x0, x1, rx, ry);
    // one apparent geometry for every device.
    win_en <= en;
    app_x0 <= x0;
    app_x1 <= x1;
    real_x <= rx;
    real_y <= ry;
    // changes land only at frame start.
    frame_ev <= 1'b1;
    @(posedge ref_clk);
    frame_ev <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic run_line(input logic [11:0] y);
    int k;
    xfers = 0;
    bits = 0;
    ck = 32'h0;
    done_seen = 1'b0;
    line_y <= y;
    line_start <= 1'b1;
    @(posedge ref_clk);
    line_start <= 1'b0;
    for (k = 0; k < 3000 && !done_seen; k++) @(posedge ref_clk);
    for (k = 0; k < 300 && pix_valid === 1'b1; k++) @(posedge ref_clk);
    if (!done_seen) err("no line done");
  endtask

  task automatic t_plain();
    set_win(1'b0, 12'h014, 12'h034, 12'h125, 12'h200);
    run_line(12'h002);
    if (ne(xfers, 1)) err("plain xfers");
    if (ne(bits, 160)) err("plain bits");
    if (ne(xbit[0], 5'h03)) err("plain first bit");
    if (ne(xaddr[0], {12'h002, 8'h01})) err("plain addr");
    if (ne(ck, plain_ck(12'h002))) err("plain pixels");
  endtask

  task automatic t_window();
    set_win(1'b1, 12'h014, 12'h034, 12'h125, 12'h200);
    run_line(12'h003);
    if (ne(xfers, 3)) err("win xfers");
    if (ne(xbit[1], 5'h05)) err("win first bit");
    if (ne(xaddr[1], {12'h200, 8'h12})) err("win addr");
    if (ne(bits, 160)) err("win bits");
    set_win(1'b1, 12'h014, 12'h034, 12'h125, 12'h210);
    run_line(12'h003);
    if (ne(xaddr[1], {12'h210, 8'h12})) err("scroll addr");
  endtask

  task automatic t_outside();
    run_line(12'h00c);
    if (ne(xfers, 1)) err("below window");
    set_win(1'b1, 12'h300, 12'h320, 12'h125, 12'h200);
    run_line(12'h003);
    if (ne(xfers, 1)) err("off screen");
  endtask

  task automatic t_equal();
    set_win(1'b0, 12'h014, 12'h034, 12'h014, 12'h003);
    run_line(12'h003);
    ck_ref = ck;
    set_win(1'b1, 12'h014, 12'h034, 12'h014, 12'h003);
    run_line(12'h003);
    if (ne(ck, ck_ref)) err("equal origin");
    set_win(1'b1, 12'h014, 12'h034, 12'h125, 12'h200);
    run_line(12'h003);
    if (!ne(ck, ck_ref)) err("planes kept");
  endtask

  // A stalled pixel side must hold the fetch near its threshold, not overflow.
  task automatic t_stall();
    set_win(1'b0, 12'h014, 12'h034, 12'h125, 12'h200);
    screen_w <= 12'h400;
    pix_ready <= 1'b0;
    fork
      run_line(12'h005);
      begin
        repeat (400) @(posedge ref_clk);
        if (ne(lnk.fifo_level >= 8'h30 && lnk.fifo_level <= 8'h40, 1)) err("stall");
        pix_ready <= 1'b1;
      end
    join
    if (ne(bits, 1024)) err("stall bits");
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_plain();
    t_window();
    t_outside();
    t_equal();
    t_stall();
    finish_test();
  end

  // A hang is cut short well above the expected run length.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      finish_test();
    end
  end
endmodule // tb
